// file: pmf_port_mux.sv
// Design: general ports and pin function hand-over of the port block
`timescale 1ns/1ps
// Overview of operation
// - Upper output-4 pins carry data or buzzer per select bit; selects reset 0.
// - Buzzer not selected: data bit drives pin; otherwise data bit is storage.
// - Lower output-4 data bits drive pins only outside memory mode; reset 1.
// - Outside memory mode float bit 1 floats pin, 0 drives it.
// - Per-pin direction bit, 1 output, 0 input, reset to input.
// - Per-pin pull-up bit, 1 on while the pin is an input, reset to 1.
// - Memory mode makes ports 0-2 direction and pull-up bits plain storage.
// - Memory mode turns port 0/1 data into external data bus bits.
// - Outside memory mode port 2 data is ordinary pin data.
// - Memory mode port 2 data drives four active-low memory selects.
// - Port 3 select bits route osc, timer, LCD frame and clock outputs.
// - Routed port 3 pins turn their control bits into storage.
// - Serial enable bit hands port 4 to the serial link; reset 0.
// - Serial on: pins 0,1 bits are storage; pin 0 pull-up serves serial input.
// - Pin 2 taken in synchronous modes, pin 3 only in synchronous slave.
// - Two-bit serial mode field, reset to synchronous master.
// - One memory mode bit switches ports to memory bus role; reset 0.
// - Unused register bits read zero and ignore writes.
module pmf_port_mux (
   input wire logic sys_clk,
   input wire logic resetn,
   input pmf_pkg::pmf_bus_t cpu_bus,
   output logic [3:0] cpu_rdata,
   input wire logic buzzer_signal,
   input wire logic [1:0] ext_strobe,
   input wire logic ext_bus_drive,
   input wire logic divided_osc_output,
   input wire logic timer_overflow_output,
   input wire logic lcd_alternation_output,
   input wire logic lcd_latch_pulse,
   input wire logic serial_txd,
   input wire logic serial_clk_out,
   input wire logic serial_rdy,
   output logic serial_data_input,
   output logic serial_clk_in,
   output logic ext_memory_mode,
   output logic serial_port_takeover,
   output pmf_pkg::pmf_smode_t serial_link_mode,
   output pmf_pkg::pmf_pin_t out4_pins,
   input wire logic [4:0][3:0] port_pin_i,
   output pmf_pkg::pmf_pin_t [4:0] port_pins
);
   import pmf_pkg::*;

   logic [3:0] out4_dat_reg;
   logic [3:0] out4_sel_reg;
   logic [3:0] out4_hiz_reg;
   logic [3:0] port3_sel_reg;
   logic ext_reg;
   logic [2:0] ser_reg;
   logic [4:0][3:0] dir_reg;
   logic [4:0][3:0] pup_reg;
   logic [4:0][3:0] dat_reg;
   logic [3:0] rdata_reg;
   logic [3:0] rdata_next;
   logic [4:0][3:0] rd_pin;
   logic [3:0] alt_out;
   logic sync_mode;
   logic slave_mode;

   // Write decode used by every register
   function automatic logic wr_hit(input pmf_bus_t b, input logic [7:0] ofs);
      wr_hit = b.wr && (b.addr == ofs);
   endfunction : wr_hit

   assign ext_memory_mode = ext_reg;
   assign serial_port_takeover = ser_reg[PMF_SEREN_BIT];
   assign serial_link_mode = pmf_smode_t'(ser_reg[PMF_MODE_LSB +: 2]);
   assign sync_mode = (serial_link_mode == PMF_SYNC_MASTER) || (serial_link_mode == PMF_SYNC_SLAVE);
   assign slave_mode = serial_link_mode == PMF_SYNC_SLAVE;
   assign alt_out = {divided_osc_output, timer_overflow_output,
                     lcd_alternation_output, lcd_latch_pulse};
   assign cpu_rdata = rdata_reg;
   assign serial_data_input = port_pin_i[4][0];
   assign serial_clk_in = port_pin_i[4][2];

   // Memory mode control bit
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ext_reg <= 1'b0;
      end else if (wr_hit(cpu_bus, PMF_EXT_OFS)) begin
         ext_reg <= cpu_bus.wdata[PMF_EXT_BIT];
      end
   end

   // Serial enable and mode field
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ser_reg <= PMF_SER_RST;
      end else if (wr_hit(cpu_bus, PMF_SER_OFS)) begin
         ser_reg <= cpu_bus.wdata[2:0];
      end
   end

   // Output port 4 data, float and function select
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         out4_dat_reg <= PMF_O4DAT_RST;
         out4_hiz_reg <= PMF_O4HIZ_RST;
         out4_sel_reg <= PMF_O4SEL_RST;
      end else begin
         if (wr_hit(cpu_bus, PMF_O4DAT_OFS)) begin
            out4_dat_reg <= cpu_bus.wdata;
         end
         if (wr_hit(cpu_bus, PMF_O4HIZ_OFS)) begin
            out4_hiz_reg <= cpu_bus.wdata;
         end
         if (wr_hit(cpu_bus, PMF_O4SEL_OFS)) begin
            out4_sel_reg <= cpu_bus.wdata & PMF_O4SEL_MASK;
         end
      end
   end

   // Port 3 function select
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         port3_sel_reg <= PMF_P3SEL_RST;
      end else if (wr_hit(cpu_bus, PMF_P3SEL_OFS)) begin
         port3_sel_reg <= cpu_bus.wdata;
      end
   end

   // Direction, pull-up and data of the five bidirectional ports
   for (genvar p = 0; p < 5; p++) begin : g_port
      always_ff @(posedge sys_clk) begin
         if (!resetn) begin
            dir_reg[p] <= PMF_DIR_RST;
            pup_reg[p] <= PMF_PUP_RST;
            dat_reg[p] <= PMF_DAT_RST;
         end else begin
            if (wr_hit(cpu_bus, PMF_DIR_OFS[p])) begin
               dir_reg[p] <= cpu_bus.wdata;
            end
            if (wr_hit(cpu_bus, PMF_PUP_OFS[p])) begin
               pup_reg[p] <= cpu_bus.wdata;
            end
            if (wr_hit(cpu_bus, PMF_DAT_OFS[p])) begin
               dat_reg[p] <= cpu_bus.wdata;
            end
         end
      end
   end

   // Output port 4 pin drive
   always_comb begin
      out4_pins.pull = 4'h0;
      out4_pins.drv[3] = out4_sel_reg[PMF_BUZ_BIT] ? buzzer_signal : out4_dat_reg[3];
      out4_pins.drv[2] = out4_sel_reg[PMF_IBUZ_BIT] ? !buzzer_signal : out4_dat_reg[2];
      out4_pins.oe[3:2] = ~out4_hiz_reg[3:2];
      if (ext_reg) begin
         // Memory strobes own the lower pins; data and float bits are storage
         out4_pins.drv[1:0] = ext_strobe;
         out4_pins.oe[1:0] = 2'b11;
      end else begin
         out4_pins.drv[1:0] = out4_dat_reg[1:0];
         out4_pins.oe[1:0] = ~out4_hiz_reg[1:0];
      end
   end

   // Bidirectional pins: normal I/O first, then each take-over
   always_comb begin
      for (int p = 0; p < 5; p++) begin
         port_pins[p].drv = dat_reg[p];
         port_pins[p].oe = dir_reg[p];
         port_pins[p].pull = pup_reg[p] & ~dir_reg[p];
         rd_pin[p] = ~dir_reg[p];
      end
      if (ext_reg) begin
         // Data bus: driven only during a memory write cycle
         for (int p = 0; p < 2; p++) begin
            port_pins[p].oe = {4{ext_bus_drive}};
            port_pins[p].pull = 4'h0;
            rd_pin[p] = 4'hF;
         end
         // Active-low memory selects, always driven
         port_pins[2].oe = 4'hF;
         port_pins[2].pull = 4'h0;
         rd_pin[2] = 4'h0;
      end
      for (int b = 0; b < 4; b++) begin
         if (port3_sel_reg[b]) begin
            port_pins[3].drv[b] = alt_out[b];
            port_pins[3].oe[b] = 1'b1;
            port_pins[3].pull[b] = 1'b0;
            rd_pin[3][b] = 1'b0;
         end
      end
      if (ser_reg[PMF_SEREN_BIT]) begin
         // Serial data in: pull-up bit keeps a meaning
         port_pins[4].oe[0] = 1'b0;
         port_pins[4].pull[0] = pup_reg[4][0];
         rd_pin[4][0] = 1'b0;
         // Serial data out
         port_pins[4].drv[1] = serial_txd;
         port_pins[4].oe[1] = 1'b1;
         port_pins[4].pull[1] = 1'b0;
         rd_pin[4][1] = 1'b0;
         if (sync_mode) begin
            // Clock out as master, clock in as slave
            port_pins[4].drv[2] = serial_clk_out;
            port_pins[4].oe[2] = !slave_mode;
            port_pins[4].pull[2] = 1'b0;
            rd_pin[4][2] = 1'b0;
         end
         if (slave_mode) begin
            port_pins[4].drv[3] = serial_rdy;
            port_pins[4].oe[3] = 1'b1;
            port_pins[4].pull[3] = 1'b0;
            rd_pin[4][3] = 1'b0;
         end
      end
   end

   // Read multiplexer; unmapped addresses and unused bits read zero
   always_comb begin
      rdata_next = 4'h0;
      case (cpu_bus.addr)
         PMF_EXT_OFS: rdata_next[PMF_EXT_BIT] = ext_reg;
         PMF_O4HIZ_OFS: rdata_next = out4_hiz_reg;
         PMF_O4DAT_OFS: rdata_next = out4_dat_reg;
         PMF_O4SEL_OFS: rdata_next = out4_sel_reg;
         PMF_P3SEL_OFS: rdata_next = port3_sel_reg;
         PMF_SER_OFS: rdata_next = {1'b0, ser_reg};
         default: rdata_next = 4'h0;
      endcase
      for (int p = 0; p < 5; p++) begin
         if (cpu_bus.addr == PMF_DIR_OFS[p]) begin
            rdata_next = dir_reg[p];
         end
         if (cpu_bus.addr == PMF_PUP_OFS[p]) begin
            rdata_next = pup_reg[p];
         end
         if (cpu_bus.addr == PMF_DAT_OFS[p]) begin
            rdata_next = (port_pin_i[p] & rd_pin[p]) | (dat_reg[p] & ~rd_pin[p]);
         end
      end
   end

   // Read data register, loaded on a read strobe
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rdata_reg <= 4'h0;
      end else if (cpu_bus.rd) begin
         rdata_reg <= rdata_next;
      end
   end

   // Checks
   property p_buzzer;
      @(posedge sys_clk) disable iff (!resetn)
      wr_hit(cpu_bus, PMF_O4SEL_OFS) && cpu_bus.wdata[3] |=> out4_pins.drv[3] == buzzer_signal;
   endproperty
   a_buzzer: assert property (p_buzzer) else $error("buzzer not on pin");

   property p_out4_data;
      @(posedge sys_clk) disable iff (!resetn)
      wr_hit(cpu_bus, PMF_O4DAT_OFS) && !out4_sel_reg[3] |=> out4_pins.drv[3] == $past(cpu_bus.wdata[3]);
   endproperty
   a_out4_data: assert property (p_out4_data) else $error("data bit not on pin");

   property p_strobes;
      @(posedge sys_clk) disable iff (!resetn)
      wr_hit(cpu_bus, PMF_EXT_OFS) && cpu_bus.wdata[3] |=>
         out4_pins.oe[1:0] == 2'b11 && out4_pins.drv[1:0] == ext_strobe;
   endproperty
   a_strobes: assert property (p_strobes) else $error("memory strobes not routed");

   property p_float;
      @(posedge sys_clk) disable iff (!resetn)
      !ext_reg && wr_hit(cpu_bus, PMF_O4HIZ_OFS) && cpu_bus.wdata[0] |=> !out4_pins.oe[0];
   endproperty
   a_float: assert property (p_float) else $error("float bit ignored");

   property p_dir;
      @(posedge sys_clk) disable iff (!resetn)
      !ext_reg && wr_hit(cpu_bus, PMF_DIR_OFS[1]) |=> port_pins[1].oe == $past(cpu_bus.wdata);
   endproperty
   a_dir: assert property (p_dir) else $error("direction not applied");

   property p_reset_vals;
      @(posedge sys_clk) !resetn |=> pup_reg[0] == PMF_PUP_RST && out4_dat_reg == PMF_O4DAT_RST && !ext_reg;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

   property p_selects;
      @(posedge sys_clk) disable iff (!resetn)
      ext_reg && wr_hit(cpu_bus, PMF_DAT_OFS[2]) |=>
         port_pins[2].oe == 4'hF && port_pins[2].drv == $past(cpu_bus.wdata);
   endproperty
   a_selects: assert property (p_selects) else $error("selects not driven");

   property p_alt3;
      @(posedge sys_clk) disable iff (!resetn)
      wr_hit(cpu_bus, PMF_P3SEL_OFS) && cpu_bus.wdata[3] |=>
         port_pins[3].oe[3] && port_pins[3].drv[3] == divided_osc_output;
   endproperty
   a_alt3: assert property (p_alt3) else $error("osc output not routed");

   property p_pull_input;
      @(posedge sys_clk) disable iff (!resetn)
      (port_pins[0].pull & port_pins[0].oe) == 4'h0;
   endproperty
   a_pull_input: assert property (p_pull_input) else $error("pull-up on driven pin");

   property p_unused;
      @(posedge sys_clk) disable iff (!resetn)
      cpu_bus.rd && cpu_bus.addr == PMF_O4SEL_OFS |=> cpu_rdata[1:0] == 2'b00;
   endproperty
   a_unused: assert property (p_unused) else $error("unused bits read nonzero");

   property p_serial_pins;
      @(posedge sys_clk) disable iff (!resetn)
      serial_port_takeover |-> port_pins[4].oe[1:0] == 2'b10 && port_pins[4].drv[1] == serial_txd;
   endproperty
   a_serial_pins: assert property (p_serial_pins) else $error("serial data pins not taken over");

   property p_async_frees;
      @(posedge sys_clk) disable iff (!resetn)
      serial_port_takeover && serial_link_mode == PMF_ASYNC8 |-> port_pins[4].oe[3:2] == dir_reg[4][3:2];
   endproperty
   a_async_frees: assert property (p_async_frees) else $error("asynchronous mode took pins 2 and 3");

   property p_slave_pins;
      @(posedge sys_clk) disable iff (!resetn)
      serial_port_takeover && serial_link_mode == PMF_SYNC_SLAVE |-> port_pins[4].oe[3:2] == 2'b10;
   endproperty
   a_slave_pins: assert property (p_slave_pins) else $error("slave mode pins not taken over");

   property p_mem_bus;
      @(posedge sys_clk) disable iff (!resetn)
      ext_memory_mode |-> port_pins[0].oe == {4{ext_bus_drive}} && port_pins[1].pull == 4'h0;
   endproperty
   a_mem_bus: assert property (p_mem_bus) else $error("data bus pins not in memory role");

   property p_serial_reset;
      @(posedge sys_clk) !resetn |=> !serial_port_takeover && serial_link_mode == PMF_SYNC_MASTER;
   endproperty
   a_serial_reset: assert property (p_serial_reset) else $error("serial controls not reset");

   c_ext: cover property (@(posedge sys_clk) disable iff (!resetn) ext_reg && ext_bus_drive);
   c_buzz: cover property (@(posedge sys_clk) disable iff (!resetn) out4_sel_reg[3] && out4_sel_reg[2]);
   c_slave: cover property (@(posedge sys_clk) disable iff (!resetn) ser_reg[0] && slave_mode);
   c_alt: cover property (@(posedge sys_clk) disable iff (!resetn) port3_sel_reg == 4'hF);

endmodule : pmf_port_mux

// file: pmf_pkg.sv
// Package: register map, reset values and carriers for the port function mux
package pmf_pkg;
   localparam logic [7:0] PMF_EXT_OFS = 8'h98;
   localparam logic [7:0] PMF_O4HIZ_OFS = 8'hA8;
   localparam logic [7:0] PMF_O4DAT_OFS = 8'hA9;
   localparam logic [7:0] PMF_O4SEL_OFS = 8'hAA;
   localparam logic [7:0] PMF_P3SEL_OFS = 8'hBF;
   localparam logic [7:0] PMF_SER_OFS = 8'hC8;
   // Per-port offsets, port 4 first
   localparam logic [4:0][7:0] PMF_DIR_OFS =
      {8'hC0, 8'hBC, 8'hB8, 8'hB4, 8'hB0};
   localparam logic [4:0][7:0] PMF_PUP_OFS =
      {8'hC1, 8'hBD, 8'hB9, 8'hB5, 8'hB1};
   localparam logic [4:0][7:0] PMF_DAT_OFS =
      {8'hC2, 8'hBE, 8'hBA, 8'hB6, 8'hB2};
   // Field positions
   localparam int PMF_EXT_BIT = 3;
   localparam int PMF_SEREN_BIT = 0;
   localparam int PMF_MODE_LSB = 1;
   localparam int PMF_BUZ_BIT = 3;
   localparam int PMF_IBUZ_BIT = 2;
   // Reset values and output-4 select write mask
   localparam logic [3:0] PMF_O4DAT_RST = 4'h3;
   localparam logic [3:0] PMF_O4SEL_RST = 4'h0;
   localparam logic [3:0] PMF_O4HIZ_RST = 4'h0;
   localparam logic [3:0] PMF_DIR_RST = 4'h0;
   localparam logic [3:0] PMF_PUP_RST = 4'hF;
   localparam logic [3:0] PMF_DAT_RST = 4'h0;
   localparam logic [3:0] PMF_P3SEL_RST = 4'h0;
   localparam logic [2:0] PMF_SER_RST = 3'h0;
   localparam logic [3:0] PMF_O4SEL_MASK = 4'hC;
   // Serial link modes
   typedef enum logic [1:0] {
      PMF_SYNC_MASTER = 2'b00,
      PMF_SYNC_SLAVE = 2'b01,
      PMF_ASYNC7 = 2'b10,
      PMF_ASYNC8 = 2'b11
   } pmf_smode_t;
   // CPU access to the I/O memory space
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [3:0] wdata;
   } pmf_bus_t;
   // One four-pin group: level driven, driver enable, pull-up enable
   typedef struct packed {
      logic [3:0] drv;
      logic [3:0] oe;
      logic [3:0] pull;
   } pmf_pin_t;
endpackage : pmf_pkg

// file: pmf_pin_world.sv
// Partner: wires, pull-ups and outside parts hanging on the port pins
`timescale 1ns/1ps
module pmf_pin_world
   import pmf_pkg::*;
(
   input wire logic sys_clk,
   input pmf_pkg::pmf_pin_t [4:0] port_pins,
   input wire logic [4:0][3:0] ext_oe,
   input wire logic [4:0][3:0] ext_val,
   output logic [4:0][3:0] pin_level,
   output logic [3:0] mem_sel
);
   logic [4:0][3:0] float_pat = 20'h5A5A5;
   // Undriven pins without pull-up wander, so a stale level is never seen
   always @(posedge sys_clk) begin
      float_pat <= ~float_pat;
   end
   // Wire level: block driver, else outside driver, else pull-up, else floating
   always_comb begin
      for (int p = 0; p < 5; p++) begin
         pin_level[p] = (port_pins[p].oe & port_pins[p].drv) | (~port_pins[p].oe & ext_oe[p] & ext_val[p])
            | (~port_pins[p].oe & ~ext_oe[p] & (port_pins[p].pull | float_pat[p]));
      end
   end
   // Memory chips see their selects active low
   assign mem_sel = ~pin_level[2];
endmodule : pmf_pin_world

// file: pmf_port_mux_tb_top.sv
// Testbench: self-checking bench of the port function mux
`timescale 1ns/1ps
module pmf_port_mux_tb_top;
   import pmf_pkg::*;
   localparam logic [7:0] REG_ADDR [0:6] = '{PMF_EXT_OFS, PMF_O4HIZ_OFS, PMF_O4DAT_OFS, PMF_O4SEL_OFS,
      PMF_P3SEL_OFS, PMF_SER_OFS, 8'hCF};
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   pmf_bus_t cpu_bus = '0;
   logic [3:0] cpu_rdata;
   logic buzzer_signal = 1'b0;
   logic [1:0] ext_strobe = 2'h0;
   logic ext_bus_drive = 1'b0;
   logic [3:0] src = 4'h0;
   logic [2:0] ser_src = 3'h0;
   logic serial_data_input, serial_clk_in, ext_memory_mode, serial_port_takeover;
   pmf_smode_t serial_link_mode;
   pmf_pin_t out4_pins;
   pmf_pin_t [4:0] port_pins;
   logic [4:0][3:0] pin_level;
   logic [4:0][3:0] ext_oe = '0;
   logic [4:0][3:0] ext_val = '0;
   logic [3:0] mem_sel;
   logic ext_on = 1'b0;
   // Bench copy of the registers, starting from their reset values
   logic [4:0][3:0] dir_s = '0;
   logic [4:0][3:0] pup_s = '1;
   logic [4:0][3:0] dat_s = '0;
   logic [3:0] o4d_s = 4'h3;
   logic [3:0] o4s_s = 4'h0;
   logic [3:0] o4h_s = 4'h0;
   logic [3:0] p3s_s = 4'h0;
   logic ext_s = 1'b0;
   logic ser_s = 1'b0;
   logic [1:0] mode_s = 2'h0;
   int mismatches = 0;
   int comparisons = 0;

   // Clock of 25 ns
   always #12.5 sys_clk = ~sys_clk;

   pmf_port_mux DUT (.sys_clk(sys_clk), .resetn(resetn), .cpu_bus(cpu_bus), .cpu_rdata(cpu_rdata),
      .buzzer_signal(buzzer_signal), .ext_strobe(ext_strobe), .ext_bus_drive(ext_bus_drive),
      .divided_osc_output(src[3]), .timer_overflow_output(src[2]), .lcd_alternation_output(src[1]),
      .lcd_latch_pulse(src[0]), .serial_txd(ser_src[0]), .serial_clk_out(ser_src[1]), .serial_rdy(ser_src[2]),
      .serial_data_input(serial_data_input), .serial_clk_in(serial_clk_in), .ext_memory_mode(ext_memory_mode),
      .serial_port_takeover(serial_port_takeover), .serial_link_mode(serial_link_mode), .out4_pins(out4_pins),
      .port_pin_i(pin_level), .port_pins(port_pins));

   pmf_pin_world WORLD (.sys_clk(sys_clk), .port_pins(port_pins), .ext_oe(ext_oe), .ext_val(ext_val),
      .pin_level(pin_level), .mem_sel(mem_sel));

   // Expected drive, enable and pull-up of one port
   function automatic pmf_pin_t exp_pin(input int p);
      pmf_pin_t e;
      e.drv = dat_s[p];
      e.oe = dir_s[p];
      e.pull = pup_s[p] & ~dir_s[p];
      if (p < 3 && ext_s) begin
         e.oe = (p == 2) ? 4'hF : {4{ext_bus_drive}};
         e.pull = 4'h0;
      end
      if (p == 3) begin
         e.drv = (e.drv & ~p3s_s) | (src & p3s_s);
         e.oe = e.oe | p3s_s;
         e.pull = e.pull & ~p3s_s;
      end
      if (p == 4 && ser_s) begin
         e.oe[1:0] = 2'h2;
         e.drv[1] = ser_src[0];
         e.pull[1:0] = {1'b0, pup_s[4][0]};
         if (!mode_s[1]) begin
            e.oe[2] = !mode_s[0];
            e.drv[2] = ser_src[1];
            e.pull[2] = 1'b0;
         end
         if (mode_s == 2'b01) begin
            e.oe[3] = 1'b1;
            e.drv[3] = ser_src[2];
            e.pull[3] = 1'b0;
         end
      end
      return e;
   endfunction : exp_pin

   // Expected output port four
   function automatic pmf_pin_t exp_out4();
      pmf_pin_t e;
      e.pull = 4'h0;
      e.oe = ~o4h_s;
      e.drv = o4d_s;
      if (o4s_s[3]) e.drv[3] = buzzer_signal;
      if (o4s_s[2]) e.drv[2] = ~buzzer_signal;
      if (ext_s) begin
         e.oe[1:0] = 2'h3;
         e.drv[1:0] = ext_strobe;
      end
      return e;
   endfunction : exp_out4

   // Expected wire level of one port
   function automatic logic [3:0] lvl(input int p);
      pmf_pin_t e;
      e = exp_pin(p);
      return (e.oe & e.drv) | (~e.oe & ext_oe[p] & ext_val[p]) | (~e.oe & ~ext_oe[p] & e.pull);
   endfunction : lvl

   // Data bits that read the wire rather than the stored bit
   function automatic logic [3:0] rd_pin(input int p);
      logic [3:0] t;
      t = (p == 3) ? p3s_s : 4'h0;
      if (p == 4 && ser_s) t = {mode_s == 2'b01, !mode_s[1], 2'h3};
      if (p < 2 && ext_s) return 4'hF;
      if (p == 2 && ext_s) return 4'h0;
      return ~t & ~dir_s[p];
   endfunction : rd_pin

   // Expected read value of an address
   function automatic logic [3:0] exp_rd(input logic [7:0] a);
      logic [3:0] r;
      r = 4'h0;
      if (a == PMF_EXT_OFS) r = {ext_s, 3'h0};
      if (a == PMF_O4HIZ_OFS) r = o4h_s;
      if (a == PMF_O4DAT_OFS) r = o4d_s;
      if (a == PMF_O4SEL_OFS) r = o4s_s;
      if (a == PMF_P3SEL_OFS) r = p3s_s;
      if (a == PMF_SER_OFS) r = {1'b0, mode_s, ser_s};
      for (int p = 0; p < 5; p++) begin
         if (a == PMF_DIR_OFS[p]) r = dir_s[p];
         if (a == PMF_PUP_OFS[p]) r = pup_s[p];
         if (a == PMF_DAT_OFS[p]) r = (dat_s[p] & ~rd_pin(p)) | (lvl(p) & rd_pin(p));
      end
      return r;
   endfunction : exp_rd

   // Address number k of the 22 places visited
   function automatic logic [7:0] pick(input int k);
      if (k < 7) return REG_ADDR[k];
      case ((k - 7) % 3)
         0: return PMF_DIR_OFS[(k - 7) / 3];
         1: return PMF_PUP_OFS[(k - 7) / 3];
         default: return PMF_DAT_OFS[(k - 7) / 3];
      endcase
   endfunction : pick

   task automatic stop_test();
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   task automatic check_reg(input logic [3:0] got, input logic [3:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_reg

   task automatic check_pins(input pmf_pin_t got, input pmf_pin_t exp, input string what);
      comparisons++;
      if (got.oe !== exp.oe || got.pull !== exp.pull || (got.drv & exp.oe) !== (exp.drv & exp.oe)) begin
         mismatches++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_pins

   // One write cycle, strobe held for one edge
   task automatic reg_wr(input logic [7:0] a, input logic [3:0] d);
      @(posedge sys_clk);
      cpu_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      cpu_bus <= '0;
      if (a == PMF_EXT_OFS) ext_s = d[3];
      if (a == PMF_O4HIZ_OFS) o4h_s = d;
      if (a == PMF_O4DAT_OFS) o4d_s = d;
      if (a == PMF_O4SEL_OFS) o4s_s = d & 4'hC;
      if (a == PMF_P3SEL_OFS) p3s_s = d;
      if (a == PMF_SER_OFS) {mode_s, ser_s} = d[2:0];
      for (int p = 0; p < 5; p++) begin
         if (a == PMF_DIR_OFS[p]) dir_s[p] = d;
         if (a == PMF_PUP_OFS[p]) pup_s[p] = d;
         if (a == PMF_DAT_OFS[p]) dat_s[p] = d;
      end
      #1;
   endtask : reg_wr

   // One read cycle, data taken once the strobe edge has landed
   task automatic reg_rd(input logic [7:0] a, output logic [3:0] d);
      @(posedge sys_clk);
      cpu_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 4'h0};
      @(posedge sys_clk);
      cpu_bus <= '0;
      #1;
      d = cpu_rdata;
   endtask : reg_rd

   // New random levels on the function sources and outside drivers
   task automatic rand_inputs(input logic ebd);
      @(posedge sys_clk);
      buzzer_signal <= 1'($urandom);
      ext_strobe <= 2'($urandom);
      ext_bus_drive <= ebd;
      src <= 4'($urandom);
      ser_src <= 3'($urandom);
      ext_val <= 20'($urandom);
      #1;
   endtask : rand_inputs

   // Outside parts drive only pins that the block leaves free, then all is compared
   task automatic check_all();
      pmf_pin_t e;
      logic [3:0] d;
      logic [3:0] l4;
      for (int p = 0; p < 5; p++) begin
         e = exp_pin(p);
         ext_oe[p] = ext_on ? ~e.oe : 4'h0;
      end
      #1;
      for (int p = 0; p < 5; p++) begin
         check_pins(port_pins[p], exp_pin(p), "port pins");
      end
      check_pins(out4_pins, exp_out4(), "out4 pins");
      l4 = lvl(4);
      check_reg(mem_sel, ~lvl(2), "memory selects");
      check_reg({3'h0, ext_memory_mode}, {3'h0, ext_s}, "memory mode");
      check_reg({1'b0, serial_link_mode, serial_port_takeover}, {1'b0, mode_s, ser_s}, "serial cfg");
      check_reg({2'h0, serial_clk_in, serial_data_input}, {2'h0, l4[2], l4[0]}, "serial in");
      for (int k = 0; k < 22; k++) begin
         reg_rd(pick(k), d);
         check_reg(d, exp_rd(pick(k)), "read");
      end
   endtask : check_all

   // Watchdog well beyond the expected run length
   initial begin
      #(25 * 10000);
      mismatches++;
      stop_test();
   end

   // Main sequence
   initial begin
      void'($urandom(39418));
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      #1;
      check_all();
      ext_on = 1'b1;
      reg_wr(PMF_O4SEL_OFS, 4'hF);
      reg_wr(PMF_EXT_OFS, 4'hF);
      reg_wr(8'hCF, 4'hF);
      reg_wr(PMF_DIR_OFS[0], 4'hF);
      reg_wr(PMF_PUP_OFS[1], 4'h0);
      reg_wr(PMF_DAT_OFS[2], 4'h5);
      for (int m = 0; m < 4; m++) begin
         reg_wr(PMF_SER_OFS, {1'b1, 2'(m), 1'b1});
         rand_inputs(m[0]);
         check_all();
      end
      reg_wr(PMF_EXT_OFS, 4'h0);
      reg_wr(PMF_P3SEL_OFS, 4'hF);
      reg_wr(PMF_O4SEL_OFS, 4'h0);
      reg_wr(PMF_O4DAT_OFS, 4'hA);
      reg_wr(PMF_O4HIZ_OFS, 4'h5);
      reg_wr(PMF_DIR_OFS[1], 4'h6);
      check_all();
      for (int i = 0; i < 40; i++) begin
         rand_inputs(1'($urandom));
         reg_wr(pick($urandom_range(21)), 4'($urandom));
         check_all();
      end
      stop_test();
   end
endmodule : pmf_port_mux_tb_top
